// ### testbench/mss_coord_model.sv
// Purpose: Coordinator and peer module model for the scan sequencer
// Assumes: Coordinator scan of 40 clocks, driven on the falling edge
// Notes: Peer link lines show inverted data when not strobed

`timescale 1ns/1ns

module mss_coord_model
  import mss_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] mode_req,
  input wire logic evt_ack,
  output logic coord_scan_start,
  output logic [1:0] coord_mode,
  output logic evt_req,
  output logic link_rx_stb,
  output logic [63:0] link_rx_bits
);
  // ****************************************
  // Coordinator scan
  // ****************************************
  int cnt_q;
  logic [63:0] pat_q;
  logic run_q;

  // Reset seen on the rising edge so it never races the falling-edge drive
  always @(posedge mclk) run_q <= rstn;

  always @(negedge mclk) begin
    if (!run_q) begin
      cnt_q <= 0;
      coord_mode <= MODE_PROG;
      evt_req <= 1'b0;
      pat_q <= 64'h0123456789abcdef;
    end else begin
      cnt_q <= (cnt_q == 39) ? 0 : cnt_q + 1;
      // Mid-scan change keeps the follow delay unambiguous
      if (cnt_q == 20) coord_mode <= mode_req;
      if (cnt_q == 0) evt_req <= 1'b1;
      else if (evt_ack) evt_req <= 1'b0;
      if (cnt_q == 8) pat_q <= ~{pat_q[62:0], pat_q[63]};
    end
  end

  assign coord_scan_start = (cnt_q < 4);
  assign link_rx_stb = (cnt_q == 7);
  assign link_rx_bits = link_rx_stb ? pat_q : ~pat_q;
endmodule : mss_coord_model

// ### testbench/tb_motion_module_scan_sync.sv
// Purpose: Self-checking bench for the scan sequencer
// Assumes: Coordinator model scans every 40 clocks
// Notes: Inputs change on the falling edge

`timescale 1ns/1ns

module tb_motion_module_scan_sync;
  import mss_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic sync_mode = 1'b0;
  logic sync_src_period = 1'b0;
  logic [PER_W-1:0] sync_period_code = 7'h01;
  logic [1:0] mode_req = MODE_PROG;
  logic [1:0] local_mode = MODE_PROG;
  logic local_mode_wr = 1'b0;
  logic const_cyc_en = 1'b0;
  logic [CNT_W-1:0] const_cyc_len = 20'h0001e;
  logic prog_done = 1'b1;
  logic io_refresh_instr = 1'b0;
  logic user_fatal_error_instr = 1'b0;
  logic fatal_err = 1'b0;
  logic [15:0] link_tx_bits = 16'ha5c3;
  logic coord_scan_start, evt_req, evt_ack, link_rx_stb, link_tx_stb, init_done, bus_init;
  logic prog_start, io_imm_refresh, basic_in_stb, basic_out_stb, special_in_stb;
  logic shm_rd_stb, shm_wr_stb, edit_allow, fatal_active, special_out_stb;
  logic [1:0] coord_mode, op_mode;
  logic [15:0] link_tx_data;
  logic [63:0] link_rx_bits, link_rx_data, exp_rx;
  logic [CNT_W-1:0] cycle_time;
  logic [11:0] ev;
  int cnt [12];
  int tl [12];
  int cyc = 0;
  int errors = 0;
  int compares = 0;

  always #20 mclk = ~mclk;

  mss_coord_model i_mss_coord_model (.mclk, .rstn, .mode_req, .evt_ack, .coord_scan_start,
    .coord_mode, .evt_req, .link_rx_stb, .link_rx_bits);

  mss_scan_seq i_mss_scan_seq (.mclk, .rstn, .sync_mode, .sync_src_period, .sync_period_code,
    .coord_scan_start, .coord_mode, .local_mode, .local_mode_wr, .const_cyc_en,
    .const_cyc_len, .prog_done, .io_refresh_instr, .fatal_err, .user_fatal_error_instr,
    .evt_req, .link_tx_bits, .link_rx_stb, .link_rx_bits, .init_done, .bus_init, .op_mode,
    .prog_start, .io_imm_refresh, .basic_in_stb, .basic_out_stb, .special_in_stb,
    .special_out_stb, .shm_rd_stb, .shm_wr_stb, .evt_ack, .link_tx_stb, .link_tx_data,
    .link_rx_data, .edit_allow, .cycle_time, .fatal_active);

  assign ev = {special_out_stb, shm_wr_stb, init_done, bus_init, io_imm_refresh,
    special_in_stb, evt_ack,
    link_tx_stb, shm_rd_stb, basic_out_stb, basic_in_stb, prog_start};

  // Pulse counts and the cycle of each latest pulse
  always @(posedge mclk) begin
    cyc++;
    if (link_rx_stb === 1'b1) exp_rx <= link_rx_bits;
    for (int k = 0; k < 12; k++) begin
      if (ev[k] === 1'b1) begin
        cnt[k]++;
        tl[k] = cyc;
      end
    end
  end

  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wait_ev(input int k);
    int c0;
    c0 = cnt[k];
    for (int i = 0; i < 4000 && cnt[k] == c0; i++) @(negedge mclk);
    if (cnt[k] == c0) begin
      errors++;
      $display("[FAIL] %0t wait on event %0d ran out", $time, k);
      conclude();
    end
  endtask : wait_ev

  task automatic local_write(input logic [1:0] m);
    local_mode = m;
    local_mode_wr = 1'b1;
    @(negedge mclk);
    local_mode_wr = 1'b0;
  endtask : local_write

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    int s [12];
    int t;
    repeat (16) @(negedge mclk);
    chk(init_done === 1'b0, "init_done high in reset");
    rstn = 1'b1;
    wait_ev(9);
    chk(cnt[8] == 1 && op_mode === MODE_PROG, "power-up init");
    s = cnt;
    repeat (2) wait_ev(5);
    chk(cnt[0] == s[0] && cnt[2] == s[2], "program mode ran or drove outputs");
    chk(cnt[11] == s[11], "special outputs in program mode");
    chk(cnt[1] > s[1] && cnt[6] > s[6] && cnt[10] > s[10], "refresh kinds");
    chk(cnt[4] == s[4], "link sent in async");
    chk(tl[1] < tl[6] && tl[6] < tl[3] && tl[3] < tl[5], "phase order");
    local_write(MODE_RUN);
    wait_ev(0);
    chk(op_mode === MODE_RUN && edit_allow === 1'b0, "run mode");
    wait_ev(2);
    wait_ev(11);
    prog_done = 1'b0;
    wait_ev(0);
    io_refresh_instr = 1'b1;
    t = cyc;
    @(negedge mclk);
    io_refresh_instr = 1'b0;
    @(negedge mclk);
    chk(tl[7] == t + 2, "immediate refresh");
    prog_done = 1'b1;
    local_write(MODE_MON);
    repeat (2) wait_ev(3);
    chk(op_mode === MODE_MON && edit_allow === 1'b1, "monitor mode");
    const_cyc_en = 1'b1;
    repeat (3) wait_ev(3);
    chk(cycle_time >= const_cyc_len && cycle_time < 20'h00028, "constant cycle");
    const_cyc_en = 1'b0;
    mode_req = MODE_MON;
    sync_mode = 1'b1;
    repeat (3) wait_ev(4);
    chk(link_tx_data === link_tx_bits && link_rx_data === exp_rx, "link bits");
    local_write(MODE_RUN);
    repeat (2) wait_ev(4);
    chk(op_mode === MODE_MON, "local write honoured in sync");
    for (int i = 0; i < 2; i++) begin
      wait_ev(4);
      mode_req = i ? MODE_RUN : MODE_PROG;
      wait_ev(4);
      chk(op_mode === (i ? MODE_PROG : MODE_MON), "mode followed early");
      wait_ev(4);
      chk(op_mode === mode_req, "mode not followed");
    end
    wait_ev(0);
    chk(tl[0] - tl[4] == 1, "program start not aligned");
    sync_src_period = 1'b1;
    repeat (3) wait_ev(4);
    chk(cycle_time === CNT_W'(SYNC_STEP_CYC), "sync period");
    sync_src_period = 1'b0;
    sync_mode = 1'b0;
    user_fatal_error_instr = 1'b1;
    @(negedge mclk);
    user_fatal_error_instr = 1'b0;
    wait_ev(3);
    chk(fatal_active === 1'b1, "fatal not latched");
    s = cnt;
    repeat (2) wait_ev(3);
    chk(cnt[0] == s[0] && cnt[2] == s[2], "outputs after fatal");
    chk(cnt[11] == s[11], "special outputs after fatal");
    chk(cnt[1] > s[1] && cnt[10] > s[10], "inputs after fatal");
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    wait_ev(9);
    chk(fatal_active === 1'b0 && op_mode === MODE_PROG, "reset left fatal or mode");
    fatal_err = 1'b1;
    @(negedge mclk);
    fatal_err = 1'b0;
    chk(fatal_active === 1'b1, "fatal error pin not latched");
    conclude();
  end
endmodule : tb_motion_module_scan_sync

// ### verilog/mss_cycle_timer.sv
// Purpose: Cycle duration counter and programmable sync period tick
// Assumes: Period code in 0.1 ms units, same clock as the sequencer
// Notes: Code outside 1..100 is clamped

`timescale 1ns/1ns

module mss_cycle_timer
  import mss_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  mss_tmr_if.tmr t
);

  logic [CNT_W-1:0] elapsed_q;
  logic [STEP_W-1:0] step_q;
  logic [PER_W-1:0] unit_q;
  logic tick_q;
  logic [PER_W-1:0] per_w;
  logic step_end_w;
  logic unit_end_w;

  assign per_w = (t.per_code < PER_W'(SYNC_CODE_MIN)) ? PER_W'(SYNC_CODE_MIN) :
                 (t.per_code > PER_W'(SYNC_CODE_MAX)) ? PER_W'(SYNC_CODE_MAX) : t.per_code;
  assign step_end_w = (step_q == STEP_W'(SYNC_STEP_CYC - 1));
  assign unit_end_w = step_end_w && (unit_q >= per_w - PER_W'(1));
  assign t.cyc_elapsed = elapsed_q;
  assign t.sync_tick = tick_q;

  // Saturates so a stalled scan never wraps to a short time
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      elapsed_q <= '0;
    end else if (t.cyc_start) begin
      elapsed_q <= '0;
    end else if (elapsed_q != '1) begin
      elapsed_q <= elapsed_q + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      step_q <= '0;
      unit_q <= '0;
      tick_q <= 1'b0;
    end else begin
      step_q <= step_end_w ? '0 : step_q + STEP_W'(1);
      unit_q <= unit_end_w ? '0 : (step_end_w ? unit_q + PER_W'(1) : unit_q);
      tick_q <= unit_end_w;
    end
  end

endmodule : mss_cycle_timer

// ### verilog/mss_pkg.sv
// Purpose: Shared constants and types for the motion module scan sequencer
// Assumes: mclk at 25 MHz
// Notes: Mode codes match the coordinator mode pins

package mss_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int SYNC_STEP_NS = 100000;
  localparam int SYNC_STEP_CYC = (SYNC_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CODE_MIN = 1;
  localparam int SYNC_CODE_MAX = 100;
  localparam int INIT_CYC = 16;
  localparam int CNT_W = 20;
  localparam int PER_W = 7;
  localparam int STEP_W = 12;

  // ****************************************
  // Operating modes and phases
  // ****************************************
  localparam logic [1:0] MODE_PROG = 2'h0;
  localparam logic [1:0] MODE_MON = 2'h1;
  localparam logic [1:0] MODE_RUN = 2'h2;
  localparam logic [1:0] MODE_RST = MODE_PROG;

  typedef enum logic [3:0] {
    MSS_INIT, MSS_WAIT, MSS_COMMON, MSS_PROG, MSS_CTIME,
    MSS_REF_BASIC, MSS_REF_SPECIAL, MSS_REF_COORD, MSS_SERVICE
  } mss_phase_t;

  function automatic logic mss_executes(input logic [1:0] m);
    mss_executes = (m == MODE_MON) || (m == MODE_RUN);
  endfunction : mss_executes

  // Illegal code 3 falls back to the safe stopped mode
  function automatic logic [1:0] mss_legal(input logic [1:0] m);
    mss_legal = (m == MODE_MON || m == MODE_RUN) ? m : MODE_PROG;
  endfunction : mss_legal

endpackage : mss_pkg

// ### verilog/mss_scan_seq.sv
// Purpose: Scan cycle sequencer and mode follower for one motion module
// Assumes: Coordinator pins are asynchronous; program engine is on mclk
// Notes: One phase per state; program phase waits for prog_done

`timescale 1ns/1ns

// Behaviour
// R1: Sync or async chosen by coordinator setting
// R2: Async scan free running with own refresh
// R3: No sync link bit refresh in async
// R4: Async coordinator exchange via shared memory strobes
// R5: Sync scan aligned to coordinator or period
// R6: All modules start program at same edge
// R7: Link bits broadcast once per sync cycle
// R8: Received link bits from peers readable
// R9: Coordinator supplies 0.1 to 10 ms period
// R10: Program/execute change adopted one cycle later
// R11: All modules switch in same cycle
// R12: Power-up init and bus init first
// R13: Measure cycle, stretch to constant time
// R14: Immediate refresh on immediate refresh instruction
// R15: Three refresh kinds: basic, special, coordinator
// R16: Program mode or fatal refresh inputs only
// R17: Coordinator refresh continues in all conditions
// R18: Program mode never executes user program
// R19: Monitor mode executes and allows edits
// R20: Run mode executes and rejects edits
// R21: Sync mode ignores local mode change
// R22: Local mode change only in async
// R23: Sync mode follows coordinator one cycle late
// R24: Pending mode committed at cycle boundary
// R25: Fixed phase order each cycle
module mss_scan_seq
  import mss_pkg::*;
#(
  parameter int LINK_W = 16,
  parameter int PEERS = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sync_mode,
  input wire logic sync_src_period,
  input wire logic [PER_W-1:0] sync_period_code,
  input wire logic coord_scan_start,
  input wire logic [1:0] coord_mode,
  input wire logic [1:0] local_mode,
  input wire logic local_mode_wr,
  input wire logic const_cyc_en,
  input wire logic [CNT_W-1:0] const_cyc_len,
  input wire logic prog_done,
  input wire logic io_refresh_instr,
  input wire logic fatal_err,
  input wire logic user_fatal_error_instr,
  input wire logic evt_req,
  input wire logic [LINK_W-1:0] link_tx_bits,
  input wire logic link_rx_stb,
  input wire logic [LINK_W*PEERS-1:0] link_rx_bits,
  output logic init_done,
  output logic bus_init,
  output logic [1:0] op_mode,
  output logic prog_start,
  output logic io_imm_refresh,
  output logic basic_in_stb,
  output logic basic_out_stb,
  output logic special_in_stb,
  output logic special_out_stb,
  output logic shm_rd_stb,
  output logic shm_wr_stb,
  output logic evt_ack,
  output logic link_tx_stb,
  output logic [LINK_W-1:0] link_tx_data,
  output logic [LINK_W*PEERS-1:0] link_rx_data,
  output logic edit_allow,
  output logic [CNT_W-1:0] cycle_time,
  output logic fatal_active
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic scan_s3_q;
  logic sync_mode_s;
  logic src_period_s;
  logic [1:0] coord_mode_s;
  logic scan_edge_w;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      scan_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {sync_mode, sync_src_period, coord_mode, coord_scan_start};
      pin_s2_q <= pin_s1_q;
      scan_s3_q <= pin_s2_q[0];
    end
  end

  assign sync_mode_s = pin_s2_q[4]; // R1
  assign src_period_s = pin_s2_q[3];
  assign coord_mode_s = mss_legal(pin_s2_q[2:1]);
  assign scan_edge_w = pin_s2_q[0] && !scan_s3_q;

  // ****************************************
  // Phase sequencer
  // ****************************************
  mss_tmr_if tmr ();
  mss_phase_t state_q, state_d;
  logic [4:0] init_cnt_q;
  logic align_pend_q;
  logic align_evt_w;
  logic go_w;
  logic cyc_start_w;
  logic [1:0] mode_q;
  logic [1:0] pend_q;
  logic fatal_q;
  logic exec_w;
  logic seen_cyc_q;
  logic stretch_w;
  logic ctime_en_q;

  mss_cycle_timer u_tmr (
    .mclk(mclk),
    .rstn(rstn),
    .t(tmr.tmr)
  );

  assign align_evt_w = src_period_s ? tmr.sync_tick : scan_edge_w; // R5 R9
  assign go_w = !sync_mode_s || align_pend_q || align_evt_w; // R2 R6
  assign cyc_start_w = (state_q == MSS_WAIT) && go_w;
  assign tmr.cyc_start = cyc_start_w;
  assign tmr.per_code = sync_period_code;
  assign exec_w = mss_executes(mode_q) && !fatal_q && !fatal_err; // R18
  assign stretch_w = const_cyc_en && (tmr.cyc_elapsed < const_cyc_len); // R13

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MSS_INIT: if (init_cnt_q == 5'(INIT_CYC - 1)) state_d = MSS_WAIT; // R12
      MSS_WAIT: if (go_w) state_d = MSS_COMMON;
      MSS_COMMON: state_d = exec_w ? MSS_PROG : MSS_CTIME; // R25
      MSS_PROG: if (prog_done) state_d = MSS_CTIME;
      MSS_CTIME: if (!stretch_w) state_d = MSS_REF_BASIC;
      MSS_REF_BASIC: state_d = MSS_REF_SPECIAL;
      MSS_REF_SPECIAL: state_d = MSS_REF_COORD;
      MSS_REF_COORD: state_d = MSS_SERVICE;
      MSS_SERVICE: state_d = MSS_WAIT;
      default: state_d = MSS_WAIT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= MSS_INIT;
      init_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == MSS_INIT) init_cnt_q <= init_cnt_q + 5'd1;
    end
  end

  // A missed alignment event is held, one deep, so a long scan still starts the next cycle; set wins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      align_pend_q <= 1'b0;
    end else if (align_evt_w && state_q != MSS_WAIT) begin
      align_pend_q <= 1'b1;
    end else if (cyc_start_w) begin
      align_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // Operating mode
  // ****************************************
  // Sampled at one boundary, committed at the next: one cycle late in sync mode; a local write in async commits at once
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
      pend_q <= MODE_RST;
    end else if (state_q == MSS_INIT) begin
      mode_q <= coord_mode_s; // R12
      pend_q <= coord_mode_s;
    end else if (sync_mode_s) begin
      if (cyc_start_w) begin
        mode_q <= pend_q; // R10 R11 R23 R24
        pend_q <= coord_mode_s;
      end
    end else if (local_mode_wr) begin
      mode_q <= mss_legal(local_mode); // R21 R22
      pend_q <= mss_legal(local_mode);
    end
  end

  // Whether the ending cycle left its timing phase under a constant cycle time
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctime_en_q <= 1'b0;
    end else if (state_q == MSS_CTIME && !stretch_w) begin
      ctime_en_q <= const_cyc_en; // R13
    end
  end

  // Fatal state held until reset, like the user fatal instruction
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fatal_q <= 1'b0;
      seen_cyc_q <= 1'b0;
      cycle_time <= '0;
    end else begin
      if (fatal_err || user_fatal_error_instr) fatal_q <= 1'b1;
      if (cyc_start_w) begin
        seen_cyc_q <= 1'b1;
        cycle_time <= tmr.cyc_elapsed + CNT_W'(1); // R13
      end
    end
  end

  // ****************************************
  // Phase outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prog_start <= 1'b0;
      io_imm_refresh <= 1'b0;
      basic_in_stb <= 1'b0;
      basic_out_stb <= 1'b0;
      special_in_stb <= 1'b0;
      special_out_stb <= 1'b0;
      shm_rd_stb <= 1'b0;
      shm_wr_stb <= 1'b0;
      evt_ack <= 1'b0;
      bus_init <= 1'b0;
      link_tx_stb <= 1'b0;
      link_tx_data <= '0;
    end else begin
      bus_init <= (state_q == MSS_INIT) && (init_cnt_q == 5'd0); // R12
      prog_start <= (state_q == MSS_COMMON) && exec_w; // R18 R19 R20
      io_imm_refresh <= (state_q == MSS_PROG) && io_refresh_instr; // R14
      basic_in_stb <= (state_q == MSS_REF_BASIC); // R15
      basic_out_stb <= (state_q == MSS_REF_BASIC) && exec_w; // R16
      special_in_stb <= (state_q == MSS_REF_SPECIAL);
      special_out_stb <= (state_q == MSS_REF_SPECIAL) && exec_w; // R16
      shm_rd_stb <= (state_q == MSS_REF_COORD); // R4 R17
      shm_wr_stb <= (state_q == MSS_REF_COORD);
      evt_ack <= (state_q == MSS_SERVICE) && evt_req;
      link_tx_stb <= cyc_start_w && sync_mode_s; // R3 R7
      if (cyc_start_w && sync_mode_s) link_tx_data <= link_tx_bits;
    end
  end

  // Peer bits only taken in sync mode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      link_rx_data <= '0;
    end else if (link_rx_stb && sync_mode_s) begin
      link_rx_data <= link_rx_bits; // R3 R8
    end
  end

  assign init_done = (state_q != MSS_INIT);
  assign op_mode = mode_q;
  assign edit_allow = (mode_q != MODE_RUN); // R19 R20
  assign fatal_active = fatal_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_async_no_link: assert property (link_tx_stb |-> $past(sync_mode_s)) // R3
    else $error("link bits sent in async mode");
  a_tx_once_cycle: assert property (link_tx_stb |=> !link_tx_stb ##1 !link_tx_stb) // R7
    else $error("link bits sent twice in a cycle");
  a_mode_follow: assert property (cyc_start_w && sync_mode_s && init_done // R10
    |=> mode_q == $past(pend_q))
    else $error("mode not committed from pending value");
  a_sync_no_local: assert property (sync_mode_s && !cyc_start_w && init_done // R21
    |=> $stable(mode_q))
    else $error("mode changed outside boundary in sync mode");
  a_prog_no_exec: assert property (prog_start |-> $past(mss_executes(mode_q))) // R18
    else $error("program started in program mode");
  a_fatal_inputs_only: assert property (fatal_q |-> ##1 !basic_out_stb && !special_out_stb) // R16
    else $error("outputs refreshed during fatal error");
  a_immediate_io_refresh_instruction_prompt: assert property (state_q == MSS_PROG && io_refresh_instr // R14
    |=> io_imm_refresh)
    else $error("immediate refresh not performed");
  a_coord_always: assert property (state_q == MSS_REF_COORD |=> shm_rd_stb && shm_wr_stb // R17
    ##1 state_q == MSS_WAIT)
    else $error("coordinator refresh missing");
  a_const_cycle: assert property (cyc_start_w && seen_cyc_q && ctime_en_q // R13
    && $stable(const_cyc_len) |=> cycle_time >= $past(const_cyc_len))
    else $error("cycle shorter than constant time");
  a_phase_order: assert property (state_q == MSS_CTIME && !stretch_w // R25
    |=> state_q == MSS_REF_BASIC ##1 state_q == MSS_REF_SPECIAL)
    else $error("refresh phases out of order");

  c_sync_cycle: cover property (link_tx_stb ##[1:50] prog_start);
  c_mode_change: cover property (sync_mode_s && $changed(mode_q));
  c_async_cycle: cover property (!sync_mode_s && shm_wr_stb);
  c_immediate_io_refresh_instruction: cover property (io_imm_refresh);

endmodule : mss_scan_seq

// ### verilog/mss_tmr_if.sv
// Purpose: Link between scan sequencer and its cycle timer
// Assumes: Both ends on mclk
// Notes: None

`timescale 1ns/1ns

interface mss_tmr_if;
  import mss_pkg::*;
  logic cyc_start;
  logic [PER_W-1:0] per_code;
  logic [CNT_W-1:0] cyc_elapsed;
  logic sync_tick;
  modport seq (output cyc_start, output per_code, input cyc_elapsed, input sync_tick);
  modport tmr (input cyc_start, input per_code, output cyc_elapsed, output sync_tick);
endinterface : mss_tmr_if
